// file: logic/mlirq_pkg.sv
// Package of offsets, fields, reset values and timing for the monitor interrupt logic
package mlirq_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;
    // Register offsets
    localparam logic [7:0] OFS_HW_LIMIT_A = 8'h13;
    localparam logic [7:0] OFS_CHANNEL_MODE = 8'h16;
    localparam logic [7:0] OFS_HW_LIMIT_B = 8'h17;
    localparam logic [7:0] OFS_TEMP_HIGH = 8'h39;
    localparam logic [7:0] OFS_TEMP_LOW = 8'h3A;
    localparam logic [7:0] OFS_CONFIG_FIRST = 8'h40;
    localparam logic [7:0] OFS_STATUS_FIRST = 8'h43;
    localparam logic [7:0] OFS_STATUS_SECOND = 8'h44;
    localparam logic [7:0] OFS_INTRUSION_RST = 8'h46;
    localparam logic [7:0] OFS_CONFIG_SECOND = 8'h4A;
    localparam logic [7:0] OFS_MIRROR_FIRST = 8'h4C;
    localparam logic [7:0] OFS_MIRROR_SECOND = 8'h4D;
    // Reset values
    localparam logic [7:0] RST_HW_LIMIT = 8'h7F;
    localparam logic [7:0] RST_TEMP_HIGH = 8'h7F;
    localparam logic [7:0] RST_TEMP_LOW = 8'h80;
    localparam logic [7:0] RST_CHANNEL_MODE = 8'h80;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    // Configuration register 1 fields
    localparam int unsigned CF1_INT_ENABLE = 1;
    localparam int unsigned CF1_INT_CLEAR = 3;
    // Configuration register 2 fields
    localparam int unsigned CF2_THERMAL_MASK = 0;
    localparam int unsigned CF2_LOCK_A = 1;
    localparam int unsigned CF2_REQ_EN_LO = 4;
    // Channel mode fields
    localparam int unsigned CM_REQ_BLOCK_OFF = 7;
    localparam int unsigned CM_REQ_EN_LO = 0;
    // Intrusion reset control field
    localparam int unsigned IR_PULSE = 7;
    // Second status register fields
    localparam int unsigned ST2_INT_TEMP = 0;
    localparam int unsigned ST2_EXT_TEMP = 1;
    localparam int unsigned ST2_OVERTEMP_IN = 2;
    localparam int unsigned ST2_CASE_OPEN = 3;
    // Request inputs: low ones active low, the rest active high
    localparam int unsigned REQ_LOW_COUNT = 3;
    localparam int unsigned REQ_COUNT = 5;
    // Timing
    localparam longint unsigned CLK_HZ = 20000000;
    localparam longint unsigned CASE_RST_TIME_MS = 20;
    localparam longint unsigned CASE_RST_CYCLES_DEF = (CASE_RST_TIME_MS * CLK_HZ + 999) / 1000;
    localparam logic [7:0] DAC_FULL_SCALE = 8'hFF;
endpackage

// file: logic/mlirq_top.sv
// Interrupt aggregation, status capture and pin control of the hardware monitor
// Behaviour
// R1: Intrusion-reset bit pulls case-open low 20 ms
// R2: External overtemp pull sets its status bit
// R3: External overtemp pull forces DAC full scale
// R4: Enabled low-active requests 0-2 assert interrupt
// R5: High-active requests need mode and config2 enable
// R6: Software identifies requests via voltage-id bits
// R7: Other sources recorded in two status registers
// R8: Overtemp output uses temperature comparisons only
// R9: Request block on when mode bit7 zero
// R10: Clear bit deasserts and blocks interrupt
// R11: Status at 43h/44h, mirrors 4Ch/4Dh, masked
// R12: Conversion end sets out-of-limit voltage/fan bits
// R13: Unmasked set status bit asserts interrupt
// R14: Status read clears bits and interrupt
// R15: Still out of limits sets again
// R16: Status stays set after quantity recovers
// R17: Internal temp compared to high/low limits
// R18: Internal temp compared to hardware limits
// R19: Temperature crossing out of range sets status
// R20: Persistent temperature error raises no new interrupt
// R21: Opposite crossing or reprogrammed limit re-arms
// R22: Clear bit halts the conversion loop
// R23: Interrupt output driven only when enabled
// R24: Interrupt is OR of all qualified sources
module mlirq_top #(
    parameter longint unsigned CASE_RST_CYCLES = mlirq_pkg::CASE_RST_CYCLES_DEF,
    parameter int unsigned VF_COUNT = 8
) (
    input wire logic CLK_SYS, // 20 MHz system clock
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic CLK_EN, // Freezes all state while low
    input wire logic [mlirq_pkg::AW-1:0] REG_ADDR, // Register index from the serial interface
    input wire logic [mlirq_pkg::DW-1:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe, one cycle
    input wire logic REG_RD, // Read strobe, one cycle
    output logic [mlirq_pkg::DW-1:0] REG_RDATA, // Read data, valid cycle after strobe
    input wire logic CONV_DONE, // Pulse at end of round-robin conversion cycle
    input wire logic [VF_COUNT-1:0] VF_OUT_OF_LIMIT, // Voltage/fan comparison errors
    input wire logic [7:0] INT_TEMP, // Internal temperature, two's complement
    input wire logic EXT_TEMP_OUT_OF_LIMIT, // External temperature high/low error
    input wire logic EXT_TEMP_HW_ERR, // External temperature hardware limit error
    input wire logic CASE_OPEN_I, // Case-open line level
    output logic CASE_OPEN_O, // Case-open drive level, always low
    output logic CASE_OPEN_OE, // Case-open drive enable
    input wire logic OVERTEMP_LINE_N_I, // Overtemp line level
    input wire logic OVERTEMP_DRIVE, // Our overtemp output currently active
    input wire logic [mlirq_pkg::REQ_COUNT-1:0] EXT_REQUEST_INPUTS, // External requests
    input wire logic [7:0] DAC_SETTING, // Programmed fan DAC value
    output logic [7:0] DAC_OUT, // Value to the fan DAC
    output logic INT_N_O, // Interrupt level, active low
    output logic INT_N_OE, // Interrupt drive enable
    output logic CONV_HALT // Stops the monitoring loop
);
    import mlirq_pkg::*;

    localparam int unsigned CNT_W = $clog2(CASE_RST_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CASE_RST_CYCLES - 1);

    logic [7:0] hw_limit_a_q;
    logic [7:0] hw_limit_b_q;
    logic [7:0] chan_mode_q;
    logic [7:0] temp_high_q;
    logic [7:0] temp_low_q;
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [7:0] mask1_q;
    logic [7:0] mask2_q;
    logic [7:0] status1_q;
    logic [7:0] status1_d;
    logic [7:0] status2_q;
    logic [7:0] status2_d;
    logic [VF_COUNT-1:0] vf_err;
    logic case_pulse_q;
    logic [CNT_W-1:0] case_cnt_q;
    logic [1:0] zone_q;
    logic [1:0] zone_d;
    logic temp_rearm_q;
    logic temp_pend_q;
    logic ext_temp_prev_q;
    logic ext_pend_q;
    logic ovt_prev_q;
    logic hw_err_q;
    logic ext_pull;
    logic conv_evt;
    logic wr_ok;
    logic rd_st1;
    logic rd_st2;
    logic temp_out;
    logic temp_fresh;
    logic ext_fresh;
    logic [REQ_COUNT-1:0] req_active;
    logic [REQ_COUNT-1:0] req_enable;
    logic int_active;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Zone code: 0 inside, 1 above high, 2 below low
    function automatic logic [1:0] zone_of(input logic [7:0] t, input logic [7:0] hi,
                                           input logic [7:0] lo);
        if ($signed(t) > $signed(hi))
        begin
            zone_of = 2'b01;
        end
        else if ($signed(t) < $signed(lo))
        begin
            zone_of = 2'b10;
        end
        else
        begin
            zone_of = 2'b00;
        end
    endfunction

    assign wr_ok = CLK_EN & REG_WR;
    assign rd_st1 = CLK_EN & REG_RD & hit(REG_ADDR, OFS_STATUS_FIRST);
    assign rd_st2 = CLK_EN & REG_RD & hit(REG_ADDR, OFS_STATUS_SECOND);
    // Conversion ends are ignored while the loop is halted
    assign conv_evt = CLK_EN & CONV_DONE & ~cfg1_q[CF1_INT_CLEAR]; // R22
    // An external pull is only visible while our own driver is idle
    assign ext_pull = ~OVERTEMP_LINE_N_I & ~OVERTEMP_DRIVE; // R2
    assign vf_err = VF_OUT_OF_LIMIT;
    assign zone_d = zone_of(INT_TEMP, temp_high_q, temp_low_q); // R17
    assign temp_out = (zone_d != 2'b00);
    // New event on leaving range, crossing to the other side, or after a limit rewrite
    assign temp_fresh = temp_out & ((zone_d != zone_q) | temp_rearm_q); // R19 R20 R21
    assign ext_fresh = EXT_TEMP_OUT_OF_LIMIT & ~ext_temp_prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < REQ_COUNT; gi = gi + 1)
        begin : g_req
            if (gi < REQ_LOW_COUNT)
            begin : g_low
                assign req_active[gi] = ~EXT_REQUEST_INPUTS[gi]; // R4
                assign req_enable[gi] = chan_mode_q[CM_REQ_EN_LO + gi]; // R9
            end
            else
            begin : g_high
                assign req_active[gi] = EXT_REQUEST_INPUTS[gi]; // R5
                assign req_enable[gi] = chan_mode_q[CM_REQ_EN_LO + gi]
                    & cfg2_q[CF2_REQ_EN_LO + gi - REQ_LOW_COUNT]; // R5
            end
        end
    endgenerate

    // Plain configuration registers
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            hw_limit_a_q <= RST_HW_LIMIT;
            hw_limit_b_q <= RST_HW_LIMIT;
            chan_mode_q <= RST_CHANNEL_MODE;
            temp_high_q <= RST_TEMP_HIGH;
            temp_low_q <= RST_TEMP_LOW;
            cfg1_q <= RST_CONFIG;
            cfg2_q <= RST_CONFIG;
            mask1_q <= RST_MASK;
            mask2_q <= RST_MASK;
        end
        else if (wr_ok)
        begin
            // Limit A is write-protected once locked; only reset unlocks it
            if (hit(REG_ADDR, OFS_HW_LIMIT_A) && !cfg2_q[CF2_LOCK_A])
                hw_limit_a_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_HW_LIMIT_B))
                hw_limit_b_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_CHANNEL_MODE))
                chan_mode_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_TEMP_HIGH))
                temp_high_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_TEMP_LOW))
                temp_low_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_CONFIG_FIRST))
                cfg1_q <= REG_WDATA;
            if (hit(REG_ADDR, OFS_CONFIG_SECOND))
                cfg2_q <= REG_WDATA | (cfg2_q & (8'h01 << CF2_LOCK_A));
            // Writes to the status offsets land in the masks
            if (hit(REG_ADDR, OFS_STATUS_FIRST))
                mask1_q <= REG_WDATA; // R11
            if (hit(REG_ADDR, OFS_STATUS_SECOND))
                mask2_q <= REG_WDATA; // R11
        end
    end

    // Status capture: a set in the clearing cycle wins over the read clear
    always_comb
    begin
        status1_d = status1_q;
        status2_d = status2_q;
        if (rd_st1)
            status1_d = RST_STATUS; // R14
        if (rd_st2)
            status2_d = RST_STATUS; // R14
        if (conv_evt)
        begin
            status1_d[VF_COUNT-1:0] = status1_d[VF_COUNT-1:0] | vf_err; // R12 R15 R16
            status2_d[ST2_INT_TEMP] = status2_d[ST2_INT_TEMP] | temp_out; // R19 R20
            status2_d[ST2_EXT_TEMP] = status2_d[ST2_EXT_TEMP] | EXT_TEMP_OUT_OF_LIMIT;
            status2_d[ST2_CASE_OPEN] = status2_d[ST2_CASE_OPEN] | CASE_OPEN_I; // R7
            status2_d[ST2_OVERTEMP_IN] = status2_d[ST2_OVERTEMP_IN] | ext_pull; // R2
        end
        if (CLK_EN && ext_pull && !ovt_prev_q)
            status2_d[ST2_OVERTEMP_IN] = 1'b1; // R2
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            status1_q <= RST_STATUS;
            status2_q <= RST_STATUS;
            ovt_prev_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            status1_q <= status1_d; // R7 R11
            status2_q <= status2_d; // R7 R11
            ovt_prev_q <= ext_pull;
        end
    end

    // Temperature interrupt pending bits: the status bit re-sets every conversion,
    // but a new interrupt only follows a fresh crossing or, for the internal temperature, a limit rewrite
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            zone_q <= 2'b00;
            temp_rearm_q <= 1'b0;
            temp_pend_q <= 1'b0;
            ext_temp_prev_q <= 1'b0;
            ext_pend_q <= 1'b0;
            hw_err_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (conv_evt)
            begin
                zone_q <= zone_d;
                ext_temp_prev_q <= EXT_TEMP_OUT_OF_LIMIT;
                // Hardware limit errors bypass status and are not read-clearable
                hw_err_q <= ($signed(INT_TEMP) > $signed(hw_limit_a_q))
                    | ($signed(INT_TEMP) > $signed(hw_limit_b_q))
                    | EXT_TEMP_HW_ERR; // R8 R18
            end
            if (wr_ok && (hit(REG_ADDR, OFS_TEMP_HIGH) || hit(REG_ADDR, OFS_TEMP_LOW)))
                temp_rearm_q <= 1'b1; // R21
            else if (conv_evt)
                temp_rearm_q <= 1'b0;
            if (conv_evt && temp_fresh)
                temp_pend_q <= 1'b1; // R19 R21
            else if (rd_st2)
                temp_pend_q <= 1'b0; // R20
            if (conv_evt && ext_fresh)
                ext_pend_q <= 1'b1;
            else if (rd_st2)
                ext_pend_q <= 1'b0;
        end
    end

    // Combine all qualified sources into one interrupt level
    always_comb
    begin
        logic thermal_ok;
        logic [7:0] st2_int;
        thermal_ok = ~cfg2_q[CF2_THERMAL_MASK];
        st2_int = status2_q;
        st2_int[ST2_INT_TEMP] = temp_pend_q;
        st2_int[ST2_EXT_TEMP] = ext_pend_q;
        st2_int[ST2_OVERTEMP_IN] = status2_q[ST2_OVERTEMP_IN] & thermal_ok;
        st2_int[ST2_INT_TEMP] = st2_int[ST2_INT_TEMP] & thermal_ok;
        st2_int[ST2_EXT_TEMP] = st2_int[ST2_EXT_TEMP] & thermal_ok;
        int_active = (|(status1_q & ~mask1_q)) // R13
            | (|(st2_int & ~mask2_q)) // R13
            | (hw_err_q & thermal_ok)
            | (~chan_mode_q[CM_REQ_BLOCK_OFF] & (|(req_active & req_enable))); // R9 R24
        int_active = int_active & ~cfg1_q[CF1_INT_CLEAR]; // R10
    end

    // Case-open reset pulse; the control bit reads back set until it ends
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            case_pulse_q <= 1'b0;
            case_cnt_q <= '0;
        end
        else if (CLK_EN)
        begin
            if (case_pulse_q)
            begin
                if (case_cnt_q == CNT_LAST)
                    case_pulse_q <= 1'b0; // R1
                case_cnt_q <= case_cnt_q + CNT_W'(1);
            end
            else if (wr_ok && hit(REG_ADDR, OFS_INTRUSION_RST) && REG_WDATA[IR_PULSE])
            begin
                case_pulse_q <= 1'b1; // R1
                case_cnt_q <= '0;
            end
        end
    end

    // Registered pin outputs
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            CASE_OPEN_O <= 1'b0;
            CASE_OPEN_OE <= 1'b0;
            DAC_OUT <= DAC_FULL_SCALE;
            INT_N_O <= 1'b1;
            INT_N_OE <= 1'b0;
            CONV_HALT <= 1'b0;
        end
        else if (CLK_EN)
        begin
            CASE_OPEN_O <= 1'b0;
            CASE_OPEN_OE <= case_pulse_q; // R1
            DAC_OUT <= ext_pull ? DAC_FULL_SCALE : DAC_SETTING; // R3
            INT_N_O <= ~int_active; // R24
            INT_N_OE <= cfg1_q[CF1_INT_ENABLE]; // R23
            CONV_HALT <= cfg1_q[CF1_INT_CLEAR]; // R22
        end
    end

    // Register read port; mirrors return status without clearing
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            REG_RDATA <= 8'h00;
        end
        else if (CLK_EN && REG_RD)
        begin
            case (REG_ADDR)
                OFS_HW_LIMIT_A: REG_RDATA <= hw_limit_a_q;
                OFS_CHANNEL_MODE: REG_RDATA <= chan_mode_q;
                OFS_HW_LIMIT_B: REG_RDATA <= hw_limit_b_q;
                OFS_TEMP_HIGH: REG_RDATA <= temp_high_q;
                OFS_TEMP_LOW: REG_RDATA <= temp_low_q;
                OFS_CONFIG_FIRST: REG_RDATA <= cfg1_q;
                OFS_STATUS_FIRST: REG_RDATA <= status1_q;
                OFS_STATUS_SECOND: REG_RDATA <= status2_q;
                OFS_INTRUSION_RST: REG_RDATA <= {case_pulse_q, 7'h00};
                OFS_CONFIG_SECOND: REG_RDATA <= cfg2_q;
                OFS_MIRROR_FIRST: REG_RDATA <= status1_q;
                OFS_MIRROR_SECOND: REG_RDATA <= status2_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end
endmodule

// file: test/mlirq_props.sv
// Port-level assertions for the monitor interrupt logic
module mlirq_props #(
    parameter longint unsigned CASE_RST_CYCLES = mlirq_pkg::CASE_RST_CYCLES_DEF,
    parameter int unsigned VF_COUNT = 8
) (
    input wire logic CLK_SYS, // clock
    input wire logic SYS_RST, // reset
    input wire logic CLK_EN, // run
    input wire logic [mlirq_pkg::AW-1:0] REG_ADDR, // index
    input wire logic [mlirq_pkg::DW-1:0] REG_WDATA, // data
    input wire logic REG_WR, // write
    input wire logic REG_RD, // read
    input wire logic [mlirq_pkg::DW-1:0] REG_RDATA, // read data
    input wire logic CONV_DONE, // cycle end
    input wire logic [VF_COUNT-1:0] VF_OUT_OF_LIMIT, // errors
    input wire logic [7:0] INT_TEMP, // temperature
    input wire logic EXT_TEMP_OUT_OF_LIMIT, // ext error
    input wire logic EXT_TEMP_HW_ERR, // ext hw error
    input wire logic CASE_OPEN_I, // case level
    input wire logic CASE_OPEN_O, // case drive
    input wire logic CASE_OPEN_OE, // case enable
    input wire logic OVERTEMP_LINE_N_I, // overtemp level
    input wire logic OVERTEMP_DRIVE, // own overtemp
    input wire logic [mlirq_pkg::REQ_COUNT-1:0] EXT_REQUEST_INPUTS, // requests
    input wire logic [7:0] DAC_SETTING, // dac value
    input wire logic [7:0] DAC_OUT, // dac out
    input wire logic INT_N_O, // int level
    input wire logic INT_N_OE, // int enable
    input wire logic CONV_HALT // halt
);
    timeunit 1ns;
    timeprecision 1ns;
    import mlirq_pkg::*;
    logic cfg_wr;
    logic en_bit;
    logic pulse_wr;
    logic mapped;
    longint unsigned run_q;
    assign cfg_wr = REG_WR && CLK_EN && REG_ADDR == OFS_CONFIG_FIRST;
    assign en_bit = REG_WDATA[CF1_INT_ENABLE];
    assign pulse_wr = REG_WR && REG_ADDR == OFS_INTRUSION_RST && REG_WDATA[IR_PULSE];
    assign mapped = REG_ADDR inside {8'h13, 8'h16, 8'h17, 8'h39, 8'h3A, 8'h40, 8'h43, 8'h44,
        8'h46, 8'h4A, 8'h4C, 8'h4D};
    // Length of the current case-open pull, reads N at the cycle it ends
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST || !CASE_OPEN_OE)
        begin
            run_q <= 0;
        end
        else
        begin
            run_q <= run_q + 1;
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);
    a_oe_follows: assert property (
        cfg_wr |-> ##2 INT_N_OE == $past(en_bit, 2))
        else $error("interrupt enable output wrong");
    a_halt_idle: assert property (
        CONV_HALT && $past(CONV_HALT) |-> INT_N_O)
        else $error("interrupt active while cleared");
    a_dac_forced: assert property (
        !OVERTEMP_LINE_N_I && !OVERTEMP_DRIVE |=> DAC_OUT == DAC_FULL_SCALE)
        else $error("dac not forced");
    a_dac_normal: assert property (
        OVERTEMP_LINE_N_I |=> DAC_OUT == $past(DAC_SETTING))
        else $error("dac not programmed value");
    a_case_low: assert property (
        CASE_OPEN_OE |-> !CASE_OPEN_O)
        else $error("case line driven high");
    a_case_start: assert property (
        pulse_wr && !CASE_OPEN_OE |-> ##[1:2] CASE_OPEN_OE)
        else $error("case pull did not start");
    a_pulse_length: assert property (
        $fell(CASE_OPEN_OE) |-> run_q == CASE_RST_CYCLES)
        else $error("case pull wrong length");
    a_unmapped_zero: assert property (
        REG_RD && !mapped |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_read_clears: assert property (
        (REG_RD && REG_ADDR == OFS_STATUS_FIRST && !CONV_DONE) ##1
        (REG_RD && REG_ADDR == OFS_STATUS_FIRST && !CONV_DONE) |=> REG_RDATA == 8'h00)
        else $error("status not cleared by read");
    a_conv_sets: assert property (
        (CONV_DONE && VF_OUT_OF_LIMIT[0] && !CONV_HALT) ##1
        (REG_RD && REG_ADDR == OFS_MIRROR_FIRST) |=> REG_RDATA[0])
        else $error("conversion error not recorded");
endmodule
bind mlirq_top mlirq_props #(.CASE_RST_CYCLES(CASE_RST_CYCLES), .VF_COUNT(VF_COUNT))
    mlirq_props_inst (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CONV_DONE(CONV_DONE), .VF_OUT_OF_LIMIT(VF_OUT_OF_LIMIT), .INT_TEMP(INT_TEMP),
    .EXT_TEMP_OUT_OF_LIMIT(EXT_TEMP_OUT_OF_LIMIT), .EXT_TEMP_HW_ERR(EXT_TEMP_HW_ERR),
    .CASE_OPEN_I(CASE_OPEN_I), .CASE_OPEN_O(CASE_OPEN_O), .CASE_OPEN_OE(CASE_OPEN_OE),
    .OVERTEMP_LINE_N_I(OVERTEMP_LINE_N_I), .OVERTEMP_DRIVE(OVERTEMP_DRIVE),
    .EXT_REQUEST_INPUTS(EXT_REQUEST_INPUTS), .DAC_SETTING(DAC_SETTING), .DAC_OUT(DAC_OUT),
    .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE), .CONV_HALT(CONV_HALT));

// file: test/mlirq_host.sv
// Far-side model: pulled-up interrupt wire and the external intrusion latch
module mlirq_host (
    input wire logic clk, // clock
    input wire logic int_n_o, // int level
    input wire logic int_n_oe, // int enable
    input wire logic case_o, // case level
    input wire logic case_oe, // case enable
    input wire logic intrude, // intrusion event
    output logic int_line, // resolved int wire
    output logic case_line // resolved case wire
);
    timeunit 1ns;
    timeprecision 1ns;
    logic latch_q = 1'b0;
    logic pulled;
    // Released wire reads the pull-up level, never a stale drive
    assign int_line = !(int_n_oe && !int_n_o);
    assign pulled = case_oe && !case_o;
    // The latch holds an intrusion until the device pulls the line low
    always_ff @(posedge clk)
    begin
        if (pulled)
        begin
            latch_q <= 1'b0;
        end
        else if (intrude)
        begin
            latch_q <= 1'b1;
        end
    end
    assign case_line = latch_q && !pulled;
endmodule

// file: test/monitor_limit_interrupt_logic_test.sv
// Self-checking bench for the monitor interrupt logic
module monitor_limit_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mlirq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic conv = 1'b0;
    logic [7:0] vf = 8'h00;
    logic [7:0] temp = 8'h20;
    logic ext_lim = 1'b0;
    logic pull = 1'b0;
    logic drv = 1'b0;
    logic intrude = 1'b0;
    logic [4:0] req = 5'b00111;
    logic [7:0] rdata, dac;
    logic case_o, case_oe, case_line, int_o, int_oe, int_line, halt;
    logic [7:0] oe_n = 8'h00;
    int bad_count = 0;
    int checks = 0;
    always #25 clk = ~clk;
    always @(negedge clk)
    begin
        if (case_oe)
        begin
            oe_n <= oe_n + 8'h01;
        end
    end
    mlirq_top #(.CASE_RST_CYCLES(16), .VF_COUNT(8)) mlirq_top_inst (
        .CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(en), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CONV_DONE(conv), .VF_OUT_OF_LIMIT(vf),
        .INT_TEMP(temp), .EXT_TEMP_OUT_OF_LIMIT(ext_lim), .EXT_TEMP_HW_ERR(1'b0),
        .CASE_OPEN_I(case_line), .CASE_OPEN_O(case_o), .CASE_OPEN_OE(case_oe),
        .OVERTEMP_LINE_N_I(!(pull || drv)), .OVERTEMP_DRIVE(drv), .EXT_REQUEST_INPUTS(req),
        .DAC_SETTING(8'h35), .DAC_OUT(dac), .INT_N_O(int_o), .INT_N_OE(int_oe),
        .CONV_HALT(halt));
    mlirq_host mlirq_host_inst (.clk(clk), .int_n_o(int_o), .int_n_oe(int_oe), .case_o(case_o),
        .case_oe(case_oe), .intrude(intrude), .int_line(int_line), .case_line(case_line));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cint(input logic e);
        chk({7'h00, int_line}, {7'h00, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        tick(2);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
        @(negedge clk);
    endtask
    // Two reads on consecutive edges, so no conversion can refill in between
    task automatic rreg2(input logic [7:0] a, input logic [7:0] e1, input logic [7:0] e2);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        chk(rdata, e1);
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e2);
        @(negedge clk);
    endtask
    task automatic cv;
        conv = 1'b1;
        @(negedge clk);
        conv = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    initial
    begin
        tick(6);
        rst = 1'b0;
        rreg(OFS_TEMP_HIGH, RST_TEMP_HIGH);
        rreg(OFS_TEMP_LOW, RST_TEMP_LOW);
        rreg(OFS_HW_LIMIT_B, RST_HW_LIMIT);
        rreg(OFS_CHANNEL_MODE, RST_CHANNEL_MODE);
        rreg(8'h55, 8'h00);
        wreg(OFS_CONFIG_FIRST, 8'h02);
        chk({7'h00, int_oe}, 8'h01);
        // A frozen clock enable must drop the write entirely
        en = 1'b0;
        wreg(OFS_CONFIG_FIRST, 8'h00);
        en = 1'b1;
        chk({7'h00, int_oe}, 8'h01);
        vf = 8'h81;
        cv;
        rreg(OFS_MIRROR_FIRST, 8'h81);
        cint(1'b0);
        vf = 8'h00;
        cv;
        tick(2);
        cint(1'b0);
        rreg2(OFS_STATUS_FIRST, 8'h81, 8'h00);
        cint(1'b1);
        vf = 8'h04;
        cv;
        tick(2);
        cint(1'b0);
        wreg(OFS_STATUS_FIRST, 8'h04);
        cint(1'b1);
        rreg(OFS_MIRROR_FIRST, 8'h04);
        rreg(OFS_STATUS_FIRST, 8'h04);
        rreg(OFS_MIRROR_FIRST, 8'h00);
        wreg(OFS_STATUS_FIRST, 8'h00);
        wreg(OFS_CONFIG_FIRST, 8'h0A);
        chk({7'h00, halt}, 8'h01);
        cv;
        wreg(OFS_CONFIG_FIRST, 8'h02);
        rreg(OFS_MIRROR_FIRST, 8'h00);
        vf = 8'h00;
        wreg(OFS_TEMP_HIGH, 8'h40);
        temp = 8'h50;
        cv;
        tick(2);
        cint(1'b0);
        rreg(OFS_STATUS_SECOND, 8'h01);
        cint(1'b1);
        cv;
        rreg(OFS_MIRROR_SECOND, 8'h01);
        cint(1'b1);
        wreg(OFS_TEMP_LOW, 8'h00);
        temp = 8'hF0;
        cv;
        tick(2);
        cint(1'b0);
        rreg(OFS_STATUS_SECOND, 8'h01);
        temp = 8'h20;
        wreg(OFS_HW_LIMIT_A, 8'h10);
        cv;
        tick(2);
        cint(1'b0);
        rreg(OFS_STATUS_SECOND, 8'h00);
        cint(1'b0);
        wreg(OFS_CONFIG_SECOND, 8'h01);
        cint(1'b1);
        wreg(OFS_CONFIG_SECOND, 8'h00);
        wreg(OFS_HW_LIMIT_A, RST_HW_LIMIT);
        cv;
        tick(2);
        cint(1'b1);
        ext_lim = 1'b1;
        cv;
        ext_lim = 1'b0;
        rreg(OFS_STATUS_SECOND, 8'h02);
        pull = 1'b1;
        tick(2);
        chk(dac, DAC_FULL_SCALE);
        cint(1'b0);
        pull = 1'b0;
        tick(1);
        chk(dac, 8'h35);
        rreg(OFS_STATUS_SECOND, 8'h04);
        drv = 1'b1;
        tick(2);
        cv;
        rreg(OFS_MIRROR_SECOND, 8'h00);
        drv = 1'b0;
        wreg(OFS_CHANNEL_MODE, 8'h01);
        req = 5'b00110;
        tick(2);
        cint(1'b0);
        // Software must look at the request pins: no status bit records them
        rreg(OFS_MIRROR_SECOND, 8'h00);
        wreg(OFS_CHANNEL_MODE, 8'h81);
        cint(1'b1);
        req = 5'b01111;
        wreg(OFS_CHANNEL_MODE, 8'h08);
        cint(1'b1);
        wreg(OFS_CONFIG_SECOND, 8'h10);
        cint(1'b0);
        wreg(OFS_CONFIG_FIRST, 8'h0A);
        cint(1'b1);
        wreg(OFS_CONFIG_FIRST, 8'h02);
        cint(1'b0);
        wreg(OFS_CONFIG_FIRST, 8'h00);
        chk({7'h00, int_oe}, 8'h00);
        req = 5'b00111;
        wreg(OFS_CONFIG_FIRST, 8'h02);
        intrude = 1'b1;
        tick(2);
        intrude = 1'b0;
        cv;
        rreg(OFS_STATUS_SECOND, 8'h08);
        wreg(OFS_INTRUSION_RST, 8'h80);
        rreg(OFS_INTRUSION_RST, 8'h80);
        chk({7'h00, case_line}, 8'h00);
        tick(20);
        chk(oe_n, 8'h10);
        rreg(OFS_INTRUSION_RST, 8'h00);
        report_and_stop;
    end
endmodule
